// ### rtl/acs_defines.vh
// Constants for the conversion sequencer
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
// Operating modes
`define ACS_MODE_SINGLE 2'h0
`define ACS_MODE_CONT 2'h1
`define ACS_MODE_MULTI 2'h2
`define ACS_MODE_TURBO 2'h3
// Conversions per primed sample and priming count
`define ACS_PRIME_CNT 3'h3
`define ACS_CONV_PER_SAMPLE 3'h4
// Default conversion period in clock cycles
`define ACS_CONV_CYCLES 16'h0040
// Result width
`define ACS_DATA_W 16
// FIFO depth
`define ACS_FIFO_DEPTH 32
`define ACS_FIFO_AW 5
`endif

// ### rtl/acs_fifo.v
// Result FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module acs_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData,
  // Level
  output wire isEmpty
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_r;
  reg [AW-1:0] rdPtr_r;
  reg [AW:0] count_r;
  wire doWr;
  wire doRd;
  assign inReady = (count_r != DEPTH[AW:0]);
  assign outValid = (count_r != {(AW+1){1'b0}});
  assign isEmpty = ~outValid;
  assign outData = mem[rdPtr_r];
  assign doWr = inValid & inReady;
  assign doRd = outValid & outReady;
  always @(posedge mclk) begin
    if (doWr) begin
      mem[wrPtr_r] <= inData;
    end
  end
  always @(posedge mclk) begin
    if (rst) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doRd) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      if (doWr & ~doRd) begin
        count_r <= count_r + 1'b1;
      end else if (doRd & ~doWr) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/acs_sequencer.v
// Conversion sequencer for a delta-sigma decimator
// Functional notes
// RULE1: Single mode idles until start trigger
// RULE2: Trigger in single mode runs four conversions
// RULE3: First three conversions only prime decimator
// RULE4: Fourth conversion gives valid result, done
// RULE5: Done visible as status and output
// RULE6: Single mode returns to standby after read
// RULE7: Continuous withholds first three results
// RULE8: Continuous then delivers every conversion; code drops conversions while the FIFO is full
// RULE9: Host keeps one input in continuous
// RULE10: Multi mode re-primes between samples
// RULE11: Multi mode restarts next sample automatically
// RULE12: Trigger optional for continuous operation
// RULE13: Trigger comes from clock or logic
// RULE14: Done rises on every valid result
// RULE15: Start by software bit or trigger
// RULE16: Done holds until result is read
// RULE17: Mux switch invalidates next three outputs
// RULE18: Mode field sampled idle; change aborts
`timescale 1ns/10ps
`default_nettype none
`include "acs_defines.vh"
module acs_sequencer #(
  parameter DATA_W = `ACS_DATA_W,
  parameter FIFO_DEPTH = `ACS_FIFO_DEPTH,
  parameter FIFO_AW = `ACS_FIFO_AW,
  parameter [15:0] CONV_CYCLES = `ACS_CONV_CYCLES
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Configuration and start
  input wire [1:0] modeSel,
  input wire swStart,
  input wire swStop,
  input wire startTrig,
  input wire muxSwitch,
  // Decimator side
  input wire [DATA_W-1:0] decimData,
  input wire decimDone,
  output reg decimReset_r,
  output reg modRun_r,
  // Result side
  output reg [DATA_W-1:0] result_r,
  output reg endOfConv_r,
  output reg statusDone_r,
  output reg busy_r,
  input wire resultRead
);
  // ==========================================================
  // States
  // Idle: standby, nothing converts until a start
  // Prime: conversions are counted but never kept
  // Run: the next conversion becomes a result
  // Wait: single mode only, until the last result is read
  localparam ST_IDLE = 2'd0;
  localparam ST_PRIME = 2'd1;
  localparam ST_RUN = 2'd2;
  localparam ST_WAIT = 2'd3;

  // ==========================================================
  // Input synchronisers for the pin-driven trigger
  reg trigMeta_r;
  reg trigSync_r;
  reg trigPrev_r;
  wire trigRise;
  always @(posedge mclk) begin
    if (rst) begin
      trigMeta_r <= 1'b0;
      trigSync_r <= 1'b0;
      trigPrev_r <= 1'b0;
    end else begin
      trigMeta_r <= startTrig;
      trigSync_r <= trigMeta_r;
      trigPrev_r <= trigSync_r;
    end
  end
  // Edge, so a held trigger does not retrigger back-to-back samples
  assign trigRise = trigSync_r & ~trigPrev_r;

  // ==========================================================
  // Sequencer state
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] mode_r;
  reg [1:0] mode_nxt;
  reg [2:0] convCnt_r;
  reg [2:0] convCnt_nxt;
  reg [15:0] timer_r;
  reg [15:0] timer_nxt;
  reg pushValid;
  reg decimReset_nxt;
  wire convTick;
  wire fifoInReady;
  wire fifoOutValid;
  wire [DATA_W-1:0] fifoOutData;
  wire startReq;
  wire modeChange;
  wire holdOff;

  // ==========================================================
  // Timer fallback bookkeeping
  // A strobe that turns up after the timer stood in for it would
  // count one conversion twice and let a priming result through
  // Limitation: a strobe more than one period late is skipped once, after the timer has counted its conversion twice
  reg lateSkip_r;
  reg lateSkip_nxt;
  wire timerFired;
  assign timerFired = (timer_r == 16'h0001);
  always @* begin
    lateSkip_nxt = lateSkip_r;
    if (decimReset_nxt || (state_nxt == ST_IDLE)) begin
      lateSkip_nxt = 1'b0;
    end else if (timerFired) begin
      lateSkip_nxt = lateSkip_r | ~decimDone;
    end else if (decimDone) begin
      lateSkip_nxt = 1'b0;
    end
  end
  always @(posedge mclk) begin
    if (rst) begin
      lateSkip_r <= 1'b0;
    end else begin
      lateSkip_r <= lateSkip_nxt;
    end
  end

  // RULE15: software or trigger
  // RULE12: trigger input optional
  assign startReq = swStart | trigRise;
  // RULE18: mode change aborts
  assign modeChange = (state_r != ST_IDLE) && (modeSel != mode_r);
  // Conversion completes when decimator reports it; the internal
  // timer stands in when no decimator strobe arrives in time
  assign convTick = (decimDone & ~lateSkip_r) | timerFired;
  // Back-pressure: in Run, conversions are dropped while FIFO has no room
  assign holdOff = ~fifoInReady;

  always @* begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    convCnt_nxt = convCnt_r;
    timer_nxt = timer_r;
    pushValid = 1'b0;
    decimReset_nxt = 1'b0;
    if (modeChange || swStop) begin
      state_nxt = ST_IDLE;
      decimReset_nxt = 1'b1;
      convCnt_nxt = 3'h0;
      timer_nxt = 16'h0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // RULE1: standby until start
          if (startReq) begin
            // RULE18: mode taken only here
            mode_nxt = modeSel;
            state_nxt = ST_PRIME;
            convCnt_nxt = 3'h0;
            timer_nxt = CONV_CYCLES;
            decimReset_nxt = 1'b1;
          end
        end
        ST_PRIME: begin
          if (timer_r != 16'h0000) begin
            timer_nxt = timer_r - 16'h0001;
          end
          // RULE17: mux switch re-primes
          if (muxSwitch) begin
            convCnt_nxt = 3'h0;
            timer_nxt = CONV_CYCLES;
            decimReset_nxt = 1'b1;
          end else if (convTick) begin
            timer_nxt = CONV_CYCLES;
            // RULE2: four conversions per sample
            // RULE7: three priming periods
            // RULE3: priming results dropped
            if (convCnt_r < `ACS_PRIME_CNT - 3'h1) begin
              convCnt_nxt = convCnt_r + 3'h1;
            end else begin
              convCnt_nxt = `ACS_PRIME_CNT;
              state_nxt = ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (timer_r != 16'h0000) begin
            timer_nxt = timer_r - 16'h0001;
          end
          if (muxSwitch) begin
            state_nxt = ST_PRIME;
            convCnt_nxt = 3'h0;
            timer_nxt = CONV_CYCLES;
            decimReset_nxt = 1'b1;
          end else if (convTick && !holdOff) begin
            // RULE4: fourth conversion valid
            // RULE14: done on every valid one
            pushValid = 1'b1;
            convCnt_nxt = `ACS_CONV_PER_SAMPLE;
            timer_nxt = CONV_CYCLES;
            case (mode_r)
              `ACS_MODE_SINGLE: begin
                // RULE6: back to standby
                state_nxt = ST_WAIT;
              end
              `ACS_MODE_CONT: begin
                // RULE8: no further priming
                state_nxt = ST_RUN;
              end
              default: begin
                // RULE10: reset and re-prime
                // RULE11: next sample self-starts
                state_nxt = ST_PRIME;
                convCnt_nxt = 3'h0;
                decimReset_nxt = 1'b1;
              end
            endcase
          end
        end
        ST_WAIT: begin
          // RULE6: standby after transfer
          if (!fifoOutValid && !endOfConv_r) begin
            state_nxt = ST_IDLE;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      mode_r <= `ACS_MODE_SINGLE;
      convCnt_r <= 3'h0;
      timer_r <= 16'h0000;
      decimReset_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      convCnt_r <= convCnt_nxt;
      timer_r <= timer_nxt;
      decimReset_r <= decimReset_nxt;
    end
  end

  // Status outputs follow the next state so they line up with state_r
  always @(posedge mclk) begin
    if (rst) begin
      modRun_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      modRun_r <= (state_nxt == ST_PRIME) || (state_nxt == ST_RUN);
      busy_r <= (state_nxt != ST_IDLE);
    end
  end

  // ==========================================================
  // Result buffer; the output stage drains one word at a time
  wire popFifo;
  acs_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) uFifo (
    .mclk(mclk),
    .rst(rst),
    .inValid(pushValid),
    .inReady(fifoInReady),
    .inData(decimData),
    .outValid(fifoOutValid),
    .outReady(popFifo),
    .outData(fifoOutData),
    .isEmpty()
  );

  // ==========================================================
  // Output stage: done holds until read; set beats clear
  assign popFifo = fifoOutValid & (~endOfConv_r | resultRead);
  always @(posedge mclk) begin
    if (rst) begin
      result_r <= {DATA_W{1'b0}};
      endOfConv_r <= 1'b0;
      statusDone_r <= 1'b0;
    end else begin
      // RULE16: cleared by read
      // RULE5: status and pin together
      if (popFifo) begin
        result_r <= fifoOutData;
        endOfConv_r <= 1'b1;
        statusDone_r <= 1'b1;
      end else if (resultRead) begin
        endOfConv_r <= 1'b0;
        statusDone_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/acs_seq_sva.sv
// Checker on the sequencer ports
`timescale 1ns/10ps
`default_nettype none
module acs_seq_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Watched ports
  input wire logic [1:0] modeSel,
  input wire logic swStart,
  input wire logic swStop,
  input wire logic muxSwitch,
  input wire logic resultRead,
  input wire logic [15:0] result_r,
  input wire logic decimReset_r,
  input wire logic modRun_r,
  input wire logic endOfConv_r,
  input wire logic statusDone_r,
  input wire logic busy_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ======
  // Properties
  a_stat_match: assert property (endOfConv_r == statusDone_r)
    else $error("status differs");
  a_done_holds: assert property (endOfConv_r && !resultRead && !swStop
    && !muxSwitch && !$changed(modeSel) |=> endOfConv_r && $stable(result_r))
    else $error("done dropped");
  a_idle_quiet: assert property (!busy_r |-> !modRun_r)
    else $error("idle but running");
  a_start_taken: assert property (!busy_r && swStart && !swStop
    && !$changed(modeSel) |=> busy_r && decimReset_r && modRun_r)
    else $error("start lost");
  a_mux_reprime: assert property (modRun_r && muxSwitch && !swStop
    |-> ##[1:2] decimReset_r)
    else $error("no reprime");
  a_stop_idle: assert property (swStop |-> ##[1:2] !busy_r)
    else $error("stop ignored");
  a_mode_abort: assert property (busy_r && $changed(modeSel)
    |-> ##[0:2] !busy_r)
    else $error("no abort");
  a_prime_pulse: assert property (decimReset_r |=> !decimReset_r)
    else $error("long prime");
  c_start: cover property (!busy_r ##1 busy_r);
  c_read: cover property (endOfConv_r && resultRead);
  c_abort: cover property (busy_r && $changed(modeSel));
endmodule
bind acs_sequencer acs_seq_sva chk (.mclk, .rst, .modeSel, .swStart,
  .swStop, .muxSwitch, .resultRead, .result_r, .decimReset_r, .modRun_r,
  .endOfConv_r, .statusDone_r, .busy_r);
`default_nettype wire

// ### verif/acs_decim_model.sv
// Behavioural decimator for the sequencer bench
`timescale 1ns/10ps
`default_nettype none
module acs_decim_model #(parameter int PERIOD = 4) (
  // Clock and control
  input wire logic mclk,
  input wire logic decimReset_r,
  input wire logic modRun_r,
  // Results
  output logic decimDone,
  output logic [15:0] decimData
);
  int t = 0;
  initial {decimDone, decimData} = 17'h0_0000;
  // Data counts conversions since priming, so a result shows its slot
  always @(posedge mclk) begin
    decimDone <= 1'b0;
    if (decimReset_r || !modRun_r) begin
      t <= 0;
      decimData <= 16'h0000;
    end else if (t == PERIOD - 1) begin
      t <= 0;
      decimDone <= 1'b1;
      decimData <= decimData + 16'h0001;
    end else begin
      t <= t + 1;
    end
  end
endmodule
`default_nettype wire

// ### verif/test_acs_sequencer.sv
// Self-checking bench for the sequencer
`timescale 1ns/10ps
`default_nettype none
module test_acs_sequencer;
  logic mclk = 0, rst = 1, swStart = 0, swStop = 0, startTrig = 0;
  logic muxSwitch = 0, resultRead = 0;
  logic [1:0] modeSel = 2'h0;
  logic [15:0] got;
  wire logic [15:0] decimData, result_r;
  wire logic decimDone, decimReset_r, modRun_r;
  wire logic endOfConv_r, statusDone_r, busy_r;
  int err_total = 0, check_count = 0, c;
  // ======
  // Clock, design and decimator
  always #2.5 mclk = ~mclk;
  acs_sequencer #(.CONV_CYCLES(16'h0008)) uut (.mclk, .rst, .modeSel,
    .swStart, .swStop, .startTrig, .muxSwitch, .decimData, .decimDone,
    .decimReset_r, .modRun_r, .result_r, .endOfConv_r, .statusDone_r,
    .busy_r, .resultRead);
  acs_decim_model dm (.mclk, .decimReset_r, .modRun_r, .decimDone,
    .decimData);
  task chk(input logic [15:0] g, e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge mclk);
    s = 0;
  endtask
  // Counts conversions until done, then reads; extra edge lets single mode return to idle
  task getres;
    c = 0;
    for (int i = 0; endOfConv_r !== 1'b1; i++) begin
      if (i > 300) begin
        err_total++;
        close_out;
      end
      if (decimDone === 1'b1) c++;
      @(negedge mclk);
    end
    got = result_r;
    pulse(resultRead);
    @(negedge mclk);
  endtask
  task t_single;
    modeSel = 2'h0;
    pulse(swStart);
    getres;
    chk(16'(c), 16'h0004);
    chk(got, 16'h0004);
    repeat (40) @(negedge mclk);
    chk(16'({busy_r, endOfConv_r, modRun_r}), 16'h0000);
    $display("single done");
  endtask
  task t_trig;
    pulse(startTrig);
    getres;
    chk(16'(c), 16'h0004);
    chk(got, 16'h0004);
    $display("trigger done");
  endtask
  // Trigger input stays low here: it is optional for this mode
  task t_cont;
    modeSel = 2'h1;
    pulse(swStart);
    getres;
    chk(16'(c), 16'h0004);
    getres;
    chk(got, 16'h0005);
    getres;
    chk(16'(c), 16'h0001);
    chk(got, 16'h0006);
    modeSel = 2'h2;
    repeat (3) @(negedge mclk);
    chk(16'(busy_r), 16'h0000);
    $display("continuous done");
  endtask
  task t_multi;
    modeSel = 2'h2;
    pulse(swStart);
    getres;
    chk(16'(c), 16'h0004);
    // Two conversions into the next priming, then the mux moves
    repeat (7) @(negedge mclk);
    pulse(muxSwitch);
    getres;
    chk(16'(c), 16'h0004);
    chk(got, 16'h0004);
    getres;
    chk(16'(c), 16'h0004);
    chk(got, 16'h0004);
    modeSel = 2'h3;
    repeat (3) @(negedge mclk);
    chk(16'(busy_r), 16'h0000);
    pulse(swStart);
    getres;
    chk(got, 16'h0004);
    pulse(swStop);
    repeat (3) @(negedge mclk);
    chk(16'(busy_r), 16'h0000);
    $display("multi done");
  endtask
  initial begin
    repeat (16) @(negedge mclk);
    rst = 0;
    repeat (4) @(negedge mclk);
    t_single;
    t_trig;
    t_cont;
    t_multi;
    close_out;
  end
endmodule
`default_nettype wire
